// >>> verilog/cgrpd_map.vh
// Register fields, reset values and encodings for the reset and power-down controller
`ifndef CGRPD_MAP_VH
`define CGRPD_MAP_VH
`define CGRPD_HS_N          4
`define CGRPD_LV_N          4
`define CGRPD_PLL_NORMAL    2'h0
`define CGRPD_PLL_ASYNC_PD  2'h1
`define CGRPD_PLL_SYNC_PD   2'h3
`define CGRPD_HS_PD_NORMAL  2'h0
`define CGRPD_HS_PD_SAFE    2'h2
`define CGRPD_HS_PD_FULL    2'h3
`define CGRPD_SOFT_RST_A    2
`define CGRPD_SOFT_RST_B    5
`define CGRPD_SWING_DEF     2'h2
`define CGRPD_SE_POL_DEF    3'h0
`define CGRPD_HS_PD_DEF     2'h0
`define CGRPD_PLL_PD_DEF    2'h1
`define CGRPD_ALIGN_CYCLES  4'h8
`endif

// >>> verilog/cgrpd_sync2.v
// Two-flop synchroniser with asynchronous assert of a low-active level
module cgrpd_sync2 (
  input  wire clk,
  input  wire arst_n,
  input  wire d,
  output wire q
);
  reg s1;
  reg s2;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
    end else begin
      s1 <= d;
      s2 <= s1;
    end
  end
  assign q = s2;
endmodule

// >>> verilog/cgrpd_ctrl.v
// Reset, sleep and power-down control for the clock generator outputs
`include "cgrpd_map.vh"
module cgrpd_ctrl #(
  parameter HS_N = `CGRPD_HS_N,
  parameter LV_N = `CGRPD_LV_N
) (
  input  wire              clk,
  input  wire              nrst,
  input  wire              reset_pin_n,
  input  wire              sleep_pin_n,
  input  wire              wr_en,
  input  wire [7:0]        wr_reg0,
  input  wire              update_req,
  input  wire [1:0]        buf_pll_mode,
  input  wire              buf_dist_pd,
  input  wire              buf_clk_in_pd,
  input  wire              buf_ref_one_pd,
  input  wire              buf_ref_two_pd,
  input  wire [2*HS_N-1:0] buf_hs_pd_mode,
  input  wire [2*HS_N-1:0] buf_hs_swing,
  input  wire [HS_N-1:0]   buf_hs_invert,
  input  wire [LV_N-1:0]   buf_lv_pd,
  input  wire [LV_N-1:0]   buf_lv_se_mode,
  input  wire [LV_N-1:0]   buf_lv_invert,
  input  wire [LV_N-1:0]   buf_second_en,
  input  wire [3*LV_N-1:0] buf_se_pol,
  input  wire              cp_event,
  output reg               soft_reset_active,
  output reg               update_pending,
  output reg               sleeping,
  output reg               config_port_en,
  output reg               align_active,
  output reg               pll_on,
  output reg               osc_on,
  output reg               clk_in_on,
  output reg               ref_one_on,
  output reg               ref_two_on,
  output reg               dividers_on,
  output reg               dist_bias_on,
  output reg [2*HS_N-1:0]  hs_state,
  output reg [2*HS_N-1:0]  hs_swing,
  output reg [HS_N-1:0]    hs_invert,
  output reg [LV_N-1:0]    lv_diff_on,
  output reg [LV_N-1:0]    lv_invert,
  output reg [LV_N-1:0]    single_ended_line_first,
  output reg [LV_N-1:0]    single_ended_line_second,
  output reg [3*LV_N-1:0]  se_pol
);
  // ************************************************************
  // Pin synchronisation
  // ************************************************************
  wire arst_n;
  wire rst_sync;
  wire sleep_sync;
  assign arst_n = reset_pin_n;
  cgrpd_sync2 u_rst_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .d      (1'b1),
    .q      (rst_sync)
  );
  reg sleep_s1;
  reg sleep_s2;
  always @(posedge clk) begin
    sleep_s1 <= sleep_pin_n;
    sleep_s2 <= sleep_s1;
  end
  assign sleep_sync = sleep_s2 & sleep_pin_n;

  // ************************************************************
  // Active register set
  // ************************************************************
  reg              soft_bit_a;
  reg              soft_bit_b;
  reg [1:0]        act_pll_mode;
  reg              act_dist_pd;
  reg              act_clk_in_pd;
  reg              act_ref_one_pd;
  reg              act_ref_two_pd;
  reg [2*HS_N-1:0] act_hs_pd;
  reg [2*HS_N-1:0] act_hs_swing;
  reg [HS_N-1:0]   act_hs_inv;
  reg [LV_N-1:0]   act_lv_pd;
  reg [LV_N-1:0]   act_lv_se;
  reg [LV_N-1:0]   act_lv_inv;
  reg [LV_N-1:0]   act_second;
  reg [3*LV_N-1:0] act_se_pol;
  reg              pll_pd_state;
  reg              sync_pd_wait;
  reg              upd_pulse;
  wire             soft_rst;
  wire             int_rst;
  assign soft_rst = soft_bit_a & soft_bit_b;
  assign int_rst  = ~nrst | ~rst_sync;

  // Soft reset bits: cleared by a software write, by nrst or by the reset pin
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      soft_bit_a <= 1'b0;
      soft_bit_b <= 1'b0;
    end else if (!nrst) begin
      soft_bit_a <= 1'b0;
      soft_bit_b <= 1'b0;
    end else if (wr_en) begin
      soft_bit_a <= wr_reg0[`CGRPD_SOFT_RST_A];
      soft_bit_b <= wr_reg0[`CGRPD_SOFT_RST_B];
    end
  end

  // Register transfer: defaults on any reset, buffer copy on update
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      act_pll_mode   <= `CGRPD_PLL_PD_DEF;
      act_dist_pd    <= 1'b0;
      act_clk_in_pd  <= 1'b0;
      act_ref_one_pd <= 1'b0;
      act_ref_two_pd <= 1'b0;
      act_hs_pd      <= {HS_N{`CGRPD_HS_PD_DEF}};
      act_hs_swing   <= {HS_N{`CGRPD_SWING_DEF}};
      act_hs_inv     <= {HS_N{1'b0}};
      act_lv_pd      <= {LV_N{1'b0}};
      act_lv_se      <= {LV_N{1'b0}};
      act_lv_inv     <= {LV_N{1'b0}};
      act_second     <= {LV_N{1'b0}};
      act_se_pol     <= {LV_N{`CGRPD_SE_POL_DEF}};
      upd_pulse      <= 1'b0;
      update_pending <= 1'b0;
    end else if (int_rst || soft_rst) begin
      act_pll_mode   <= `CGRPD_PLL_PD_DEF;
      act_dist_pd    <= 1'b0;
      act_clk_in_pd  <= 1'b0;
      act_ref_one_pd <= 1'b0;
      act_ref_two_pd <= 1'b0;
      act_hs_pd      <= {HS_N{`CGRPD_HS_PD_DEF}};
      act_hs_swing   <= {HS_N{`CGRPD_SWING_DEF}};
      act_hs_inv     <= {HS_N{1'b0}};
      act_lv_pd      <= {LV_N{1'b0}};
      act_lv_se      <= {LV_N{1'b0}};
      act_lv_inv     <= {LV_N{1'b0}};
      act_second     <= {LV_N{1'b0}};
      act_se_pol     <= {LV_N{`CGRPD_SE_POL_DEF}};
      upd_pulse      <= 1'b0;
      update_pending <= 1'b0;
    end else begin
      upd_pulse <= 1'b0;
      if (update_req) begin
        update_pending <= 1'b1;
      end else if (update_pending) begin
        act_pll_mode   <= buf_pll_mode;
        act_dist_pd    <= buf_dist_pd;
        act_clk_in_pd  <= buf_clk_in_pd;
        act_ref_one_pd <= buf_ref_one_pd;
        act_ref_two_pd <= buf_ref_two_pd;
        act_hs_pd      <= buf_hs_pd_mode;
        act_hs_swing   <= buf_hs_swing;
        act_hs_inv     <= buf_hs_invert;
        act_lv_pd      <= buf_lv_pd;
        act_lv_se      <= buf_lv_se_mode;
        act_lv_inv     <= buf_lv_invert;
        act_second     <= buf_second_en;
        act_se_pol     <= buf_se_pol;
        upd_pulse      <= 1'b1;
        update_pending <= 1'b0;
      end
    end
  end

  // ************************************************************
  // PLL power-down sequencing
  // ************************************************************
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pll_pd_state <= 1'b1;
      sync_pd_wait <= 1'b0;
    end else if (int_rst || soft_rst) begin
      pll_pd_state <= 1'b1;
      sync_pd_wait <= 1'b0;
    end else if (upd_pulse) begin
      case (act_pll_mode)
        `CGRPD_PLL_ASYNC_PD: begin
          pll_pd_state <= 1'b1;
          sync_pd_wait <= 1'b0;
        end
        `CGRPD_PLL_SYNC_PD: begin
          sync_pd_wait <= 1'b1;
        end
        default: begin
          pll_pd_state <= 1'b0;
          sync_pd_wait <= 1'b0;
        end
      endcase
    end else if (sync_pd_wait && cp_event) begin
      pll_pd_state <= 1'b1;
      sync_pd_wait <= 1'b0;
    end
  end

  // ************************************************************
  // Alignment sequencer
  // ************************************************************
  localparam ST_IDLE  = 2'h0;
  localparam ST_HOLD  = 2'h1;
  localparam ST_ALIGN = 2'h2;
  reg [1:0] state;
  reg [3:0] align_cnt;
  reg       dist_pd_d;
  reg       soft_d;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state     <= ST_HOLD;
      align_cnt <= 4'h0;
      dist_pd_d <= 1'b0;
      soft_d    <= 1'b0;
    end else if (int_rst) begin
      state     <= ST_HOLD;
      align_cnt <= 4'h0;
      dist_pd_d <= 1'b0;
      soft_d    <= 1'b0;
    end else begin
      dist_pd_d <= act_dist_pd;
      soft_d    <= soft_rst;
      case (state)
        ST_HOLD: begin
          state     <= ST_ALIGN;
          align_cnt <= `CGRPD_ALIGN_CYCLES;
        end
        ST_ALIGN: begin
          if (align_cnt == 4'h1) begin
            state <= ST_IDLE;
          end
          align_cnt <= align_cnt - 4'h1;
        end
        ST_IDLE: begin
          if ((soft_d && !soft_rst) || (dist_pd_d && !act_dist_pd)) begin
            state <= ST_HOLD;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Block enables
  // ************************************************************
  wire                awake;
  wire                dist_ok;
  reg  [2*HS_N-1:0]   next_hs_state;
  reg  [LV_N-1:0]     next_first;
  reg  [LV_N-1:0]     next_second;
  reg  [LV_N-1:0]     next_diff;
  integer             i;
  assign awake   = sleep_sync;
  assign dist_ok = awake & ~act_dist_pd;
  always @* begin
    next_hs_state = {2*HS_N{1'b0}};
    next_first    = {LV_N{1'b0}};
    next_second   = {LV_N{1'b0}};
    next_diff     = {LV_N{1'b0}};
    for (i = 0; i < HS_N; i = i + 1) begin
      if (!awake) begin
        next_hs_state[2*i +: 2] = `CGRPD_HS_PD_SAFE;
      end else if (act_dist_pd && act_hs_pd[2*i +: 2] == `CGRPD_HS_PD_NORMAL) begin
        next_hs_state[2*i +: 2] = `CGRPD_HS_PD_SAFE;
      end else if (act_hs_pd[2*i +: 2] == `CGRPD_HS_PD_FULL) begin
        next_hs_state[2*i +: 2] = `CGRPD_HS_PD_FULL;
      end else if (act_hs_pd[2*i +: 2] == `CGRPD_HS_PD_SAFE || act_dist_pd) begin
        next_hs_state[2*i +: 2] = `CGRPD_HS_PD_SAFE;
      end else begin
        next_hs_state[2*i +: 2] = `CGRPD_HS_PD_NORMAL;
      end
    end
    for (i = 0; i < LV_N; i = i + 1) begin
      next_first[i]  = dist_ok & ~act_lv_pd[i] & act_lv_se[i];
      next_second[i] = next_first[i] & act_second[i];
      next_diff[i]   = dist_ok & ~act_lv_pd[i] & ~act_lv_se[i];
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      soft_reset_active        <= 1'b0;
      sleeping                 <= 1'b0;
      config_port_en           <= 1'b1;
      align_active             <= 1'b0;
      pll_on                   <= 1'b0;
      osc_on                   <= 1'b0;
      clk_in_on                <= 1'b0;
      ref_one_on               <= 1'b0;
      ref_two_on               <= 1'b0;
      dividers_on              <= 1'b0;
      dist_bias_on             <= 1'b0;
      hs_state                 <= {HS_N{`CGRPD_HS_PD_SAFE}};
      hs_swing                 <= {HS_N{`CGRPD_SWING_DEF}};
      hs_invert                <= {HS_N{1'b0}};
      lv_diff_on               <= {LV_N{1'b0}};
      lv_invert                <= {LV_N{1'b0}};
      single_ended_line_first  <= {LV_N{1'b0}};
      single_ended_line_second <= {LV_N{1'b0}};
      se_pol                   <= {LV_N{`CGRPD_SE_POL_DEF}};
    end else begin
      soft_reset_active        <= soft_rst;
      sleeping                 <= ~awake;
      config_port_en           <= 1'b1;
      align_active             <= (state != ST_IDLE);
      pll_on                   <= awake & ~pll_pd_state;
      osc_on                   <= awake;
      clk_in_on                <= awake & ~act_clk_in_pd;
      ref_one_on               <= awake & ~act_ref_one_pd;
      ref_two_on               <= awake & ~act_ref_two_pd;
      dividers_on              <= dist_ok;
      dist_bias_on             <= dist_ok;
      hs_state                 <= next_hs_state;
      hs_swing                 <= act_hs_swing;
      hs_invert                <= act_hs_inv;
      lv_diff_on               <= next_diff;
      lv_invert                <= act_lv_inv;
      single_ended_line_first  <= next_first;
      single_ended_line_second <= next_second;
      se_pol                   <= act_se_pol;
    end
  end
endmodule

// >>> tb/cgrpd_ctrl_chk.sv
// Concurrent checks on the reset and power-down controller ports
module cgrpd_ctrl_chk #(
  parameter HS_N = 4,
  parameter LV_N = 4
) (
  input wire              clk,
  input wire              nrst,
  input wire              reset_pin_n,
  input wire              sleep_pin_n,
  input wire              wr_en,
  input wire              update_req,
  input wire [1:0]        buf_pll_mode,
  input wire              cp_event,
  input wire              soft_reset_active,
  input wire              update_pending,
  input wire              sleeping,
  input wire              config_port_en,
  input wire              pll_on,
  input wire [LV_N-1:0]   lv_diff_on,
  input wire [LV_N-1:0]   single_ended_line_first,
  input wire [LV_N-1:0]   single_ended_line_second,
  input wire [2*HS_N-1:0] hs_state,
  input wire [2*HS_N-1:0] hs_swing,
  input wire [3*LV_N-1:0] se_pol
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst || !reset_pin_n);
  a_port_always_on: assert property (config_port_en)
    else $error("Configuration port disabled");
  a_sleep_all_off: assert property (sleeping |-> !pll_on && lv_diff_on == '0 &&
      single_ended_line_first == '0 && hs_state == {HS_N{2'h2}})
    else $error("Blocks still on during sleep");
  a_sleep_enter: assert property (!sleep_pin_n |=> sleeping)
    else $error("Sleep not entered");
  a_update_ack: assert property (update_req && !soft_reset_active |=> update_pending)
    else $error("Transfer request not taken");
  a_soft_defaults: assert property (soft_reset_active |=> hs_swing == {HS_N{2'h2}} &&
      se_pol == '0)
    else $error("Defaults not held in soft reset");
  a_soft_no_selfclr: assert property (soft_reset_active && !wr_en && !$past(wr_en)
      |=> soft_reset_active)
    else $error("Soft reset cleared by itself");
  a_async_pll_pd: assert property (update_req && buf_pll_mode == 2'h1 &&
      !soft_reset_active && !sleeping |-> ##4 !pll_on)
    else $error("Asynchronous power-down late");
  a_sync_pll_pd: assert property ($fell(pll_on) && !sleeping && buf_pll_mode == 2'h3
      |-> $past(cp_event, 2))
    else $error("Synchronous power-down not on charge pump event");
  a_second_needs_first: assert property ((single_ended_line_second &
      ~single_ended_line_first) == '0)
    else $error("Second line on without first line");
endmodule
bind cgrpd_ctrl cgrpd_ctrl_chk #(.HS_N(HS_N), .LV_N(LV_N)) u_chk (
  .clk(clk), .nrst(nrst), .reset_pin_n(reset_pin_n), .sleep_pin_n(sleep_pin_n),
  .wr_en(wr_en), .update_req(update_req), .buf_pll_mode(buf_pll_mode), .cp_event(cp_event),
  .soft_reset_active(soft_reset_active), .update_pending(update_pending),
  .sleeping(sleeping), .config_port_en(config_port_en), .pll_on(pll_on),
  .lv_diff_on(lv_diff_on), .single_ended_line_first(single_ended_line_first),
  .single_ended_line_second(single_ended_line_second), .hs_state(hs_state),
  .hs_swing(hs_swing), .se_pol(se_pol)
);

// >>> tb/cgrpd_host.sv
// Host model driving the pins and strobes of the controller
module cgrpd_host (
  input  wire        clk,
  output logic       reset_pin_n,
  output logic       sleep_pin_n,
  output logic       wr_en,
  output logic [7:0] wr_reg0,
  output logic       update_req,
  output logic       cp_event
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Pin and strobe tasks
  // ****************************************
  initial begin
    {reset_pin_n, sleep_pin_n, wr_en, update_req, cp_event} = 5'h18;
    wr_reg0 = 8'h00;
  end
  task hold_reset(input logic lvl);
    @(negedge clk) reset_pin_n = lvl;
  endtask
  task set_sleep(input logic lvl);
    @(negedge clk) sleep_pin_n = lvl;
  endtask
  task write_reg0(input logic [7:0] v);
    @(negedge clk) wr_reg0 = v;
    wr_en = 1'b1;
    @(negedge clk) wr_en = 1'b0;
  endtask
  task update;
    @(negedge clk) update_req = 1'b1;
    @(negedge clk) update_req = 1'b0;
  endtask
  task charge_pump;
    @(negedge clk) cp_event = 1'b1;
    @(negedge clk) cp_event = 1'b0;
  endtask
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the reset and power-down controller
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, nrst, reset_pin_n, sleep_pin_n, wr_en, update_req, cp_event;
  logic [7:0]  wr_reg0, buf_hs_pd_mode, buf_hs_swing;
  logic [1:0]  buf_pll_mode;
  logic        buf_dist_pd, buf_clk_in_pd, buf_ref_one_pd, buf_ref_two_pd;
  logic [3:0]  buf_hs_invert, buf_lv_pd, buf_lv_se_mode, buf_lv_invert, buf_second_en;
  logic [11:0] buf_se_pol, se_pol;
  logic        soft_reset_active, update_pending, sleeping, config_port_en, align_active;
  logic        pll_on, osc_on, clk_in_on, ref_one_on, ref_two_on, dividers_on, dist_bias_on;
  logic [7:0]  hs_state, hs_swing;
  logic [3:0]  hs_invert, lv_diff_on, lv_invert, se_first, se_second;
  int          mismatches, n_compared, cycles;
  // ****************************************
  // Instances, clock and tasks
  // ****************************************
  cgrpd_host host (.clk(clk), .reset_pin_n(reset_pin_n), .sleep_pin_n(sleep_pin_n),
    .wr_en(wr_en), .wr_reg0(wr_reg0), .update_req(update_req), .cp_event(cp_event));
  cgrpd_ctrl dut (.clk(clk), .nrst(nrst), .reset_pin_n(reset_pin_n), .sleep_pin_n(sleep_pin_n),
    .wr_en(wr_en), .wr_reg0(wr_reg0), .update_req(update_req), .buf_pll_mode(buf_pll_mode),
    .buf_dist_pd(buf_dist_pd), .buf_clk_in_pd(buf_clk_in_pd), .buf_ref_one_pd(buf_ref_one_pd),
    .buf_ref_two_pd(buf_ref_two_pd), .buf_hs_pd_mode(buf_hs_pd_mode),
    .buf_hs_swing(buf_hs_swing), .buf_hs_invert(buf_hs_invert), .buf_lv_pd(buf_lv_pd),
    .buf_lv_se_mode(buf_lv_se_mode), .buf_lv_invert(buf_lv_invert),
    .buf_second_en(buf_second_en), .buf_se_pol(buf_se_pol), .cp_event(cp_event),
    .soft_reset_active(soft_reset_active), .update_pending(update_pending),
    .sleeping(sleeping), .config_port_en(config_port_en), .align_active(align_active),
    .pll_on(pll_on), .osc_on(osc_on), .clk_in_on(clk_in_on), .ref_one_on(ref_one_on),
    .ref_two_on(ref_two_on), .dividers_on(dividers_on), .dist_bias_on(dist_bias_on),
    .hs_state(hs_state), .hs_swing(hs_swing), .hs_invert(hs_invert), .lv_diff_on(lv_diff_on),
    .lv_invert(lv_invert), .single_ended_line_first(se_first),
    .single_ended_line_second(se_second), .se_pol(se_pol));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apply;
    host.update();
    repeat (3) @(negedge clk);
  endtask
  task end_of_test;
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      end_of_test();
    end
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    nrst = 1'b0;
    {buf_dist_pd, buf_clk_in_pd, buf_ref_one_pd, buf_ref_two_pd} = 4'h0;
    {buf_hs_invert, buf_lv_pd, buf_lv_se_mode, buf_lv_invert, buf_second_en} = 20'h0;
    {buf_pll_mode, buf_hs_pd_mode, buf_hs_swing, buf_se_pol} = {2'h1, 8'h00, 8'haa, 12'h000};
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    check({hs_swing, hs_state, lv_diff_on, se_pol}, 32'haa00f000);
    check({pll_on, config_port_en}, 2'b01);
    {buf_pll_mode, buf_hs_swing, buf_hs_invert, buf_se_pol} = {2'h0, 8'h1b, 4'h5, 12'hfa5};
    {buf_lv_se_mode, buf_lv_pd, buf_second_en, buf_lv_invert} = 16'h64f9;
    {buf_hs_pd_mode, buf_clk_in_pd, buf_ref_one_pd, buf_ref_two_pd} = {8'he0, 3'b101};
    apply();
    check({hs_swing, se_pol}, 20'h1bfa5);
    check({hs_invert, lv_invert}, 8'h59);
    check(se_pol, 12'hfa5);
    check(hs_state, 8'he0);
    check(lv_diff_on, 4'h9);
    check({se_first, se_second}, 8'h22);
    check({clk_in_on, ref_one_on, ref_two_on, pll_on}, 4'h5);
    buf_dist_pd = 1'b1;
    apply();
    check(dist_bias_on, 1'b0);
    check(hs_state, 8'hea);
    buf_dist_pd = 1'b0;
    buf_pll_mode = 2'h3;
    {buf_clk_in_pd, buf_ref_one_pd, buf_ref_two_pd} = 3'b010;
    apply();
    check({clk_in_on, ref_one_on, ref_two_on}, 3'b101);
    repeat (4) @(negedge clk);
    check(pll_on, 1'b1);
    host.charge_pump();
    repeat (2) @(negedge clk);
    check(pll_on, 1'b0);
    buf_pll_mode = 2'h2;
    apply();
    check(pll_on, 1'b1);
    buf_pll_mode = 2'h1;
    apply();
    check(pll_on, 1'b0);
    buf_pll_mode = 2'h0;
    apply();
    host.set_sleep(1'b0);
    repeat (2) @(negedge clk);
    check({sleeping, pll_on, osc_on, dividers_on, clk_in_on}, 5'h10);
    check({lv_diff_on, se_first, hs_state}, 16'h00aa);
    buf_hs_swing = 8'h66;
    apply();
    check(config_port_en, 1'b1);
    host.set_sleep(1'b1);
    repeat (5) @(negedge clk);
    check({sleeping, pll_on, hs_swing}, 10'h166);
    host.hold_reset(1'b0);
    #1;
    check({pll_on, hs_swing, hs_state}, 17'h0aaaa);
    host.hold_reset(1'b1);
    for (int i = 0; i < 20 && align_active !== 1'b1; i++) @(negedge clk);
    check(align_active, 1'b1);
    for (int i = 0; i < 30 && align_active !== 1'b0; i++) @(negedge clk);
    check(align_active, 1'b0);
    buf_hs_swing = 8'h33;
    apply();
    host.write_reg0(8'h24);
    repeat (3) @(negedge clk);
    check({soft_reset_active, hs_swing}, 9'h1aa);
    buf_hs_swing = 8'h55;
    apply();
    check({soft_reset_active, hs_swing}, 9'h1aa);
    host.write_reg0(8'h00);
    repeat (3) @(negedge clk);
    check(soft_reset_active, 1'b0);
    end_of_test();
  end
endmodule
